// *** bsm_map.svh ***
/*
  Constants for the burst SRAM byte write mask block: array geometry,
  lane layout and field positions. Included by the package and the core.
*/
`ifndef BSM_MAP_SVH
`define BSM_MAP_SVH

`define BSM_ADDR_W    4
`define BSM_DEPTH     16
`define BSM_DATA_W    36
`define BSM_LANES     4
`define BSM_LANE_W    9
`define BSM_NIB_W     4
`define BSM_X8_LANES  2
`define BSM_X18_LANES 2
`define BSM_X36_LANES 4
`define BSM_RDCNT_W   2

`endif

// *** bsm_pkg.sv ***
/*
  Types for the burst SRAM byte write mask block.
  Assumes bsm_map.svh is on the include path.
*/
`include "bsm_map.svh"

package bsm_pkg;

  // Configured data width of the part
  typedef enum logic [1:0] {
    BSM_W_X8,
    BSM_W_X9,
    BSM_W_X18,
    BSM_W_X36
  } bsm_width_t;

  // Read pipeline progress
  typedef enum logic [1:0] {
    BSM_RD_IDLE,
    BSM_RD_WAIT0,
    BSM_RD_WAIT1
  } bsm_rd_t;

  typedef logic [`BSM_DATA_W-1:0] bsm_word_t;
  typedef logic [`BSM_ADDR_W-1:0] bsm_addr_t;

  // Input clock pair and output clock pair rise strobes
  typedef struct packed {
    logic k_rise;
    logic kb_rise;
    logic c_rise;
    logic cb_rise;
  } bsm_clk_t;

  // Complete block state
  typedef struct packed {
    logic [`BSM_DEPTH-1:0][`BSM_DATA_W-1:0] mem;
    logic                                   wr_pend;
    bsm_word_t                              d0;
    bsm_word_t                              m0;
    bsm_rd_t                                rd;
    bsm_addr_t                              rd_addr;
    logic [`BSM_RDCNT_W-1:0]                rd_kcnt;
    bsm_word_t                              q;
    logic                                   oe;
    logic                                   single;
    logic                                   strap_done;
  } bsm_state_t;

endpackage : bsm_pkg

// *** bsm_core.sv ***
/*
  Burst SRAM write port lane masking and read port timing, in one module.
  Assumes clock pair rises arrive as one-cycle strobes synchronous to
  CLK_SYS, and that the controller keeps the burst sequence it is given.
*/
// Functional notes
// [RQ1] x8: select 0 writes bits 3:0, select 1 writes 7:4; high keeps contents.
// [RQ2] x18: select 0 writes bits 8:0, select 1 writes 17:9; high keeps.
// [RQ3] x9: the single select writes bits 8:0 when low, nothing when high.
// [RQ4] x36: four selects each write one nine-bit lane; others keep values.
// [RQ5] All selects high on a beat writes nothing; other beat follows its own.
// [RQ6] Selects sampled per beat on true and complement input rises independently.
// [RQ7] Write data registered on both true and complement input rises.
// [RQ8] Read data launched on output clock rises, input pair in single mode.
// [RQ9] Power-up deselected with read outputs in high impedance.
// [RQ10] Burst uses latched address for beat one, next address for beat two.
// [RQ11] Controller should hold all clocks high when stopping them.
// [RQ12] Write starts on true rise with port select low; address on next complement rise.
// [RQ13] Read at t: first word on complement rise t+1, second on true rise t+2.
// [RQ14] Burst committed only after both beats captured, each with its own mask.
`timescale 1ns/1ps
`include "bsm_map.svh"

module bsm_core (
  input  wire logic                   CLK_SYS,           // System clock, 250 MHz
  input  wire logic                   NRST,              // Synchronous reset, low
  input  wire bsm_pkg::bsm_clk_t      CLKS,              // Clock pair rise strobes
  input  wire logic                   SINGLE_CLK,        // Single clock strap
  input  wire bsm_pkg::bsm_width_t    WIDTH,             // Configured data width
  input  wire bsm_pkg::bsm_addr_t     ADDR,              // Shared address bus
  input  wire logic                   WRITE_PORT_SEL_N,  // Write port select, low
  input  wire logic                   READ_PORT_SEL_N,   // Read port select, low
  input  wire bsm_pkg::bsm_word_t     WDATA,             // Write data beat
  input  wire logic [`BSM_LANES-1:0]  LANE_WRITE_SEL_N,  // Lane selects, low
  output logic [`BSM_DATA_W-1:0]      RDATA,             // Read data
  output logic                        RDATA_OE           // Read data drive enable
);

  bsm_pkg::bsm_state_t st;
  bsm_pkg::bsm_state_t next_st;

  // Bit enables for one beat from the width and that beat's lane selects
  function automatic bsm_pkg::bsm_word_t lane_mask(bsm_pkg::bsm_width_t w,
                                                   logic [`BSM_LANES-1:0] sel_n);
    bsm_pkg::bsm_word_t m;
    m = '0;                                                               // RQ5
    case (w)
      bsm_pkg::BSM_W_X8: begin
        for (int i = 0; i < `BSM_X8_LANES; i++) begin
          m[i*`BSM_NIB_W +: `BSM_NIB_W] = {`BSM_NIB_W{~sel_n[i]}};     // RQ1
        end
      end
      bsm_pkg::BSM_W_X9: begin
        m[`BSM_LANE_W-1:0] = {`BSM_LANE_W{~sel_n[0]}};                  // RQ3
      end
      bsm_pkg::BSM_W_X18: begin
        for (int i = 0; i < `BSM_X18_LANES; i++) begin
          m[i*`BSM_LANE_W +: `BSM_LANE_W] = {`BSM_LANE_W{~sel_n[i]}};  // RQ2
        end
      end
      default: begin
        for (int i = 0; i < `BSM_X36_LANES; i++) begin
          m[i*`BSM_LANE_W +: `BSM_LANE_W] = {`BSM_LANE_W{~sel_n[i]}};  // RQ4
        end
      end
    endcase
    return m;
  endfunction : lane_mask

  // Beat two mask, address pair and output clock choice
  bsm_pkg::bsm_word_t m1;
  bsm_pkg::bsm_addr_t addr1;
  logic               wr_start;
  logic               wr_commit;
  logic               rd_start;
  logic               out_pos;
  logic               out_neg;

  assign m1        = lane_mask(WIDTH, LANE_WRITE_SEL_N);                  // RQ6
  assign addr1     = bsm_pkg::bsm_addr_t'(ADDR + 1'b1);                   // RQ10
  assign wr_start  = CLKS.k_rise && !WRITE_PORT_SEL_N;                   // RQ12
  assign wr_commit = CLKS.kb_rise && st.wr_pend;                          // RQ14
  assign rd_start  = CLKS.k_rise && !READ_PORT_SEL_N && st.rd == bsm_pkg::BSM_RD_IDLE; // RQ13
  assign out_pos   = st.single ? CLKS.k_rise : CLKS.c_rise;              // RQ8
  assign out_neg   = st.single ? CLKS.kb_rise : CLKS.cb_rise;            // RQ8

  // Next state of the write path, read pipeline and strap capture
  always_comb begin
    next_st = st;
    // Strap caught once on the first cycle after reset release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.single     = SINGLE_CLK;
    end
    // Beat one: data and mask taken on the true input rise
    if (wr_start) begin
      next_st.wr_pend = 1'b1;                                             // RQ12
      next_st.d0      = WDATA;                                            // RQ7
      next_st.m0      = lane_mask(WIDTH, LANE_WRITE_SEL_N);               // RQ6
    end
    // Beat two plus address on the complement rise, then both beats commit
    if (wr_commit) begin
      next_st.wr_pend   = 1'b0;
      next_st.mem[ADDR] = (st.mem[ADDR] & ~st.m0) | (st.d0 & st.m0);     // RQ10
      next_st.mem[addr1] = (st.mem[addr1] & ~m1) | (WDATA & m1);         // RQ7
    end
    // Count input rises since the read was taken
    if (CLKS.k_rise && st.rd != bsm_pkg::BSM_RD_IDLE) begin
      next_st.rd_kcnt = st.rd_kcnt + 1'b1;
    end
    // Read pipeline, outputs turn off on the next output rise after the burst
    case (st.rd)
      bsm_pkg::BSM_RD_IDLE: begin
        if (out_pos || out_neg) begin
          next_st.oe = 1'b0;                                              // RQ9
        end
        if (rd_start) begin
          next_st.rd      = bsm_pkg::BSM_RD_WAIT0;
          next_st.rd_addr = ADDR;
          next_st.rd_kcnt = '0;
        end
      end
      bsm_pkg::BSM_RD_WAIT0: begin
        if (out_neg && st.rd_kcnt == 2'd1) begin
          next_st.q  = st.mem[st.rd_addr];                                // RQ13
          next_st.oe = 1'b1;
          next_st.rd = bsm_pkg::BSM_RD_WAIT1;
        end else if (out_pos || out_neg) begin
          next_st.oe = 1'b0;
        end
      end
      bsm_pkg::BSM_RD_WAIT1: begin
        // The count steps to two on this same true rise, so look one rise ahead
        if (out_pos && (st.rd_kcnt == 2'd2 || (CLKS.k_rise && st.rd_kcnt == 2'd1))) begin
          next_st.q  = st.mem[bsm_pkg::bsm_addr_t'(st.rd_addr + 1'b1)];  // RQ13
          next_st.oe = 1'b1;
          next_st.rd = bsm_pkg::BSM_RD_IDLE;
        end
      end
      default: begin
        next_st.rd = bsm_pkg::BSM_RD_IDLE;
      end
    endcase
  end

  // State register; reset leaves both ports deselected and outputs off
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      st <= '0;                                                           // RQ9
    end else begin
      st <= next_st;
    end
  end

  // Registered read word and its drive enable
  assign RDATA    = st.q;
  assign RDATA_OE = st.oe;

  // A deselected lane 3 of an x36 burst keeps its old contents on beat two
  keep_lane_x36_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ4
    wr_commit && WIDTH == bsm_pkg::BSM_W_X36 && LANE_WRITE_SEL_N[3] && ADDR != addr1
    |=> st.mem[$past(addr1)][35:27] == $past(st.mem[addr1][35:27]))
    else $error("x36 lane 3 changed while deselected");

  // Selected upper nibble of a narrow beat lands in bits 7:4
  x8_upper_nibble_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ1
    wr_commit && WIDTH == bsm_pkg::BSM_W_X8 && !LANE_WRITE_SEL_N[1] && ADDR != addr1
    |=> st.mem[$past(addr1)][7:4] == $past(WDATA[7:4]))
    else $error("x8 upper nibble not written");

  // Deselected lower nibble stays as it was
  x8_lower_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ1
    wr_commit && WIDTH == bsm_pkg::BSM_W_X8 && LANE_WRITE_SEL_N[0]
    |=> st.mem[$past(addr1)][3:0] == $past(st.mem[addr1][3:0]))
    else $error("x8 lower nibble changed while deselected");

  // Deselected lower byte of a two-lane beat stays as it was
  x18_lower_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ2
    wr_commit && WIDTH == bsm_pkg::BSM_W_X18 && LANE_WRITE_SEL_N[0] && ADDR != addr1
    |=> st.mem[$past(addr1)][8:0] == $past(st.mem[addr1][8:0]))
    else $error("x18 lower byte changed while deselected");

  // Selected upper byte of a two-lane beat lands in bits 17:9
  x18_upper_write_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ2
    wr_commit && WIDTH == bsm_pkg::BSM_W_X18 && !LANE_WRITE_SEL_N[1]
    |=> st.mem[$past(addr1)][17:9] == $past(WDATA[17:9]))
    else $error("x18 upper byte not written");

  // Single-lane beat written whole when selected
  x9_write_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ3
    wr_commit && WIDTH == bsm_pkg::BSM_W_X9 && !LANE_WRITE_SEL_N[0] && ADDR != addr1
    |=> st.mem[$past(addr1)][8:0] == $past(WDATA[8:0]))
    else $error("x9 beat not written");

  // A first beat with its select high leaves the burst address alone
  x9_first_keep_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ3
    wr_commit && WIDTH == bsm_pkg::BSM_W_X9 && st.m0[0] == 1'b0
    |=> st.mem[$past(ADDR)] == $past(st.mem[ADDR]))
    else $error("x9 first beat written while deselected");

  // Selected lowest lane of a wide beat lands in bits 8:0
  x36_lane_write_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ4
    wr_commit && WIDTH == bsm_pkg::BSM_W_X36 && !LANE_WRITE_SEL_N[0]
    |=> st.mem[$past(addr1)][8:0] == $past(WDATA[8:0]))
    else $error("x36 lane 0 not written");

  // A beat with every select high writes nothing
  beat_none_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ5
    wr_commit && &LANE_WRITE_SEL_N && ADDR != addr1
    |=> st.mem[$past(addr1)] == $past(st.mem[addr1]))
    else $error("write with all lanes deselected");

  // Fully selected first beat is committed at the burst address
  first_beat_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ14
    wr_commit && &st.m0
    |=> st.mem[$past(ADDR)] == $past(st.d0))
    else $error("first beat not committed at burst address");

  // First word follows the complement output rise of the next input cycle
  read_first_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ13
    st.rd == bsm_pkg::BSM_RD_WAIT0 && out_neg && st.rd_kcnt == 2'd1
    |=> RDATA_OE && RDATA == $past(st.mem[st.rd_addr]))
    else $error("first read word not launched");

  // Second word follows the true output rise one input cycle later
  read_second_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ13
    st.rd == bsm_pkg::BSM_RD_WAIT1 && out_pos && CLKS.k_rise && st.rd_kcnt == 2'd1
    |=> RDATA_OE && RDATA == $past(st.mem[bsm_pkg::bsm_addr_t'(st.rd_addr + 1'b1)]))
    else $error("second read word not launched");

  // Outputs fall back to high impedance on the next output rise when idle
  idle_off_a: assert property (@(posedge CLK_SYS) disable iff (!NRST) // RQ9
    st.rd == bsm_pkg::BSM_RD_IDLE && !rd_start && (out_pos || out_neg) |=> !RDATA_OE)
    else $error("read outputs left on after burst");

endmodule : bsm_core

// *** bsm_ctl.sv ***
/*
  Controller model for the burst SRAM write mask block: write and read bursts.
  Assumes single clock mode, so the output clock pair strobes stay low.
*/
`timescale 1ns/1ps

module bsm_ctl (
  input  wire logic         CLK_SYS,          // System clock
  output bsm_pkg::bsm_clk_t CLKS,             // Clock pair strobes
  output bsm_pkg::bsm_addr_t ADDR,            // Burst address
  output logic              WRITE_PORT_SEL_N, // Write select, low
  output logic              READ_PORT_SEL_N,  // Read select, low
  output bsm_pkg::bsm_word_t WDATA,           // Write beat
  output logic [3:0]        LANE_WRITE_SEL_N, // Lane selects, low
  input  wire logic [35:0]  RDATA,            // Read word
  input  wire logic         RDATA_OE          // Read drive enable
);
  // Idle: no strobes, ports deselected
  initial begin
    CLKS = '0;
    ADDR = '0;
    WRITE_PORT_SEL_N = 1'b1;
    READ_PORT_SEL_N = 1'b1;
    WDATA = '0;
    LANE_WRITE_SEL_N = 4'hf;
  end

  // One system clock cycle of input clock pair rise strobes; clocks stand still when both are low
  task automatic step(input logic k, input logic kb);
    @(posedge CLK_SYS);
    #1;
    CLKS = '{k_rise: k, kb_rise: kb, c_rise: 1'b0, cb_rise: 1'b0};
  endtask : step

  // Write burst: beat one on the true rise, address and beat two on the complement
  task automatic wr(input bsm_pkg::bsm_addr_t a, input bsm_pkg::bsm_word_t d0,
                    input logic [3:0] m0, input bsm_pkg::bsm_word_t d1, input logic [3:0] m1);
    step(1'b1, 1'b0);
    WRITE_PORT_SEL_N = 1'b0;
    ADDR = ~a;
    WDATA = d0;
    LANE_WRITE_SEL_N = m0;
    step(1'b0, 1'b1);
    WRITE_PORT_SEL_N = 1'b1;
    ADDR = a;
    WDATA = d1;
    LANE_WRITE_SEL_N = m1;
  endtask : wr

  // Read burst; returns both words and the drive enable at three points
  task automatic rd(input bsm_pkg::bsm_addr_t a, output bsm_pkg::bsm_word_t w0,
                    output bsm_pkg::bsm_word_t w1, output logic [2:0] oe);
    step(1'b1, 1'b0);
    READ_PORT_SEL_N = 1'b0;
    ADDR = a;
    WDATA = ~WDATA; // Released data no longer shows the last beat
    LANE_WRITE_SEL_N = 4'hf;
    step(1'b0, 1'b1);
    READ_PORT_SEL_N = 1'b1;
    ADDR = ~a;
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    w0 = RDATA;
    oe[0] = RDATA_OE;
    step(1'b0, 1'b1);
    w1 = RDATA;
    oe[1] = RDATA_OE;
    step(1'b0, 1'b0);
    oe[2] = RDATA_OE;
  endtask : rd
endmodule : bsm_ctl

// *** tb_top.sv ***
/*
  Self-checking bench for the burst SRAM write mask core.
  Assumes bsm_map.svh, bsm_pkg and bsm_ctl are compiled first.
*/
`timescale 1ns/1ps

module tb_top;
  logic                CLK_SYS = 1'b0;
  logic                NRST = 1'b0;
  bsm_pkg::bsm_width_t WIDTH = bsm_pkg::BSM_W_X8;
  bsm_pkg::bsm_clk_t   clks;
  bsm_pkg::bsm_addr_t  addr;
  logic                wps_n;
  logic                rps_n;
  bsm_pkg::bsm_word_t  wdata;
  logic [3:0]          lane_n;
  logic [35:0]         rdata;
  logic                rdata_oe;
  int                  err_total = 0;
  int                  comparisons = 0;
  bsm_pkg::bsm_word_t  exp_mem [16];

  always #2 CLK_SYS = ~CLK_SYS;

  bsm_ctl i_ctl (.CLK_SYS(CLK_SYS), .CLKS(clks), .ADDR(addr), .WRITE_PORT_SEL_N(wps_n),
                 .READ_PORT_SEL_N(rps_n), .WDATA(wdata), .LANE_WRITE_SEL_N(lane_n),
                 .RDATA(rdata), .RDATA_OE(rdata_oe));

  bsm_core i_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .CLKS(clks), .SINGLE_CLK(1'b1),
                  .WIDTH(WIDTH), .ADDR(addr), .WRITE_PORT_SEL_N(wps_n),
                  .READ_PORT_SEL_N(rps_n), .WDATA(wdata), .LANE_WRITE_SEL_N(lane_n),
                  .RDATA(rdata), .RDATA_OE(rdata_oe));

  // Compare and count
  task automatic chk(input bsm_pkg::bsm_word_t got, input bsm_pkg::bsm_word_t expv);
    comparisons++;
    if (got !== expv) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, expv);
    end
  endtask : chk

  // Bits written by a beat for a width and its lane selects
  function automatic bsm_pkg::bsm_word_t lane_bits(input int w, input logic [3:0] s);
    lane_bits = '0;
    if (w == 0) lane_bits = {28'h0, {4{~s[1]}}, {4{~s[0]}}};
    if (w == 1) lane_bits = {27'h0, {9{~s[0]}}};
    if (w == 2) lane_bits = {18'h0, {9{~s[1]}}, {9{~s[0]}}};
    if (w == 3) lane_bits = {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
  endfunction : lane_bits

  // Write a burst and update the expected array
  task automatic put(input int w, input bsm_pkg::bsm_addr_t a, input bsm_pkg::bsm_word_t d0,
                     input logic [3:0] m0, input bsm_pkg::bsm_word_t d1, input logic [3:0] m1);
    bsm_pkg::bsm_addr_t a1;
    a1 = a + 4'h1;
    WIDTH = bsm_pkg::bsm_width_t'(w);
    i_ctl.wr(a, d0, m0, d1, m1);
    exp_mem[a] = (exp_mem[a] & ~lane_bits(w, m0)) | (d0 & lane_bits(w, m0));
    exp_mem[a1] = (exp_mem[a1] & ~lane_bits(w, m1)) | (d1 & lane_bits(w, m1));
  endtask : put

  // Read a burst and compare both words and the drive enable
  task automatic get(input bsm_pkg::bsm_addr_t a);
    bsm_pkg::bsm_word_t w0;
    bsm_pkg::bsm_word_t w1;
    logic [2:0]         oe;
    i_ctl.rd(a, w0, w1, oe);
    chk(w0, exp_mem[a]);
    chk(w1, exp_mem[a + 4'h1]);
    chk(bsm_pkg::bsm_word_t'(oe), 36'h3);
  endtask : get

  // Outputs released after reset, words 3 and 4 read back cleared
  task automatic t_reset;
    chk(rdata, 36'h0);
    chk(bsm_pkg::bsm_word_t'(rdata_oe), 36'h0);
    get(4'h3);
  endtask : t_reset

  // Every width and lane select pattern, the two beats with opposite masks
  task automatic t_lanes;
    bsm_pkg::bsm_word_t d0;
    for (int w = 0; w < 4; w++) begin
      for (int m = 0; m < 16; m++) begin
        d0 = {9{m[3:0]}} ^ {18{w[1:0]}};
        put(w, bsm_pkg::bsm_addr_t'(m), d0, m[3:0], {d0[17:0], ~d0[35:18]}, ~m[3:0]);
        get(bsm_pkg::bsm_addr_t'(m));
      end
    end
  endtask : t_lanes

  // Back-to-back bursts overlapping one word
  task automatic t_b2b;
    put(3, 4'h5, 36'h123456789, 4'h0, 36'hfedcba987, 4'h0);
    put(3, 4'h6, 36'h0a0b0c0d0, 4'h0, 36'h1e2f3a4b5, 4'h6);
    get(4'h5);
    get(4'h6);
  endtask : t_b2b

  task automatic close_out;
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  initial begin
    foreach (exp_mem[i]) exp_mem[i] = '0;
    repeat (8) @(posedge CLK_SYS);
    #1 NRST = 1'b1;
    t_reset;
    t_lanes;
    t_b2b;
    close_out();
  end

  // Watchdog well beyond the expected run of about 2.5 us
  initial begin
    #40000;
    err_total++;
    close_out();
  end
endmodule : tb_top
